// ===== dv/lcdl_ctrl_model.sv
// timing controller model: shift clock, start pulse, pixel triplets, latch strobe
// assumes the bench routes start_out to whichever pin the device reads
`timescale 1ns/1ps
module lcdl_ctrl_model
   import lcdl_pkg::*;
(
   input  wire logic                        clk_in,
   output logic                             shift_out,
   output logic                             strobe_out,
   output logic                             start_out,
   output logic [lcdl_pkg::PIXEL_W-1:0]     data_out
);
   initial begin
      shift_out = 1'b0;
      strobe_out = 1'b0;
      start_out = 1'b0;
      data_out = '0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // dot2 in the upper bits, dot0 in the lower
   function automatic logic [17:0] pix(input int i, input logic [5:0] key);
      return {6'(3 * i + 2) ^ key, 6'(3 * i + 1) ^ key, 6'(3 * i) ^ key};
   endfunction
   task automatic edge_out(input logic [17:0] d);
      data_out = d;
      tick(4);
      shift_out = 1'b1;
      tick(4);
      shift_out = 1'b0;
      data_out = ~d; // no stale value once hold is over
      tick(1); // keeps the next data change out of this time step
   endtask
   task automatic strobe();
      strobe_out = 1'b1;
      tick(8);
      strobe_out = 1'b0;
      tick(8);
   endtask
   task automatic line(input int n, input logic [5:0] key);
      start_out = 1'b1;
      tick(8);
      edge_out(18'h3ffff);
      start_out = 1'b0;
      for (int i = 0; i < n; i++) begin
         edge_out(pix(i, key));
      end
   endtask
endmodule

// ===== dv/lcdl_loader_props.sv
// checker: pin relations of the column data loader
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module lcdl_loader_props
   import lcdl_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic line_latch_strobe_in,
   input wire logic shift_direction_select_in,
   input wire logic right_start_pulse_pin_in,
   input wire logic left_start_pulse_pin_in,
   input wire logic right_start_pulse_pin_out,
   input wire logic left_start_pulse_pin_out,
   input wire logic right_start_pulse_pin_oe_n_out,
   input wire logic left_start_pulse_pin_oe_n_out,
   input wire logic [lcdl_pkg::NUM_COLUMNS*lcdl_pkg::GRAY_W-1:0] column_outputs_out,
   input wire logic [lcdl_pkg::NUM_COLUMNS-1:0] column_second_ref_out,
   input wire logic line_busy_out
);
   wire logic sel = shift_direction_select_in ? right_start_pulse_pin_in : left_start_pulse_pin_in;
   wire logic pls = right_start_pulse_pin_out || left_start_pulse_pin_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   AST_OE_EXCL: assert property (right_start_pulse_pin_oe_n_out != left_start_pulse_pin_oe_n_out)
      else $error("both start pins share one direction");
   AST_OE_DIR: assert property ($stable(shift_direction_select_in)[*5] ##0 !$past(sys_rst_in, 5)
      |-> right_start_pulse_pin_oe_n_out == shift_direction_select_in) else $error("pin role wrong");
   AST_R_OUT: assert property (right_start_pulse_pin_out |-> !right_start_pulse_pin_oe_n_out)
      else $error("right pulse while not driven");
   AST_L_OUT: assert property (left_start_pulse_pin_out |-> !left_start_pulse_pin_oe_n_out)
      else $error("left pulse while not driven");
   AST_PULSE_END: assert property ($rose(pls) |-> $past(line_busy_out))
      else $error("pulse without a line");
   AST_HOLD: assert property (!$stable({column_outputs_out, column_second_ref_out})
      |-> $past(line_latch_strobe_in, 2) || $past(line_latch_strobe_in, 3)) else $error("hold changed");
   AST_SREF: assert property (column_second_ref_out[0] |-> column_outputs_out[5:0] == 6'h00)
      else $error("second ref on nonzero code");
   AST_START: assert property ($rose(line_busy_out) |-> $past(sel, 2) || $past(sel, 3) || $past(sel, 4))
      else $error("line started without start pulse");
   cover property ($rose(line_busy_out));
   cover property ($rose(left_start_pulse_pin_out));
   cover property ($rose(right_start_pulse_pin_out));
endmodule
bind lcdl_column_data_loader lcdl_loader_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .line_latch_strobe_in(line_latch_strobe_in), .shift_direction_select_in(shift_direction_select_in),
   .right_start_pulse_pin_in(right_start_pulse_pin_in), .left_start_pulse_pin_in(left_start_pulse_pin_in),
   .right_start_pulse_pin_out(right_start_pulse_pin_out), .left_start_pulse_pin_out(left_start_pulse_pin_out),
   .right_start_pulse_pin_oe_n_out(right_start_pulse_pin_oe_n_out),
   .left_start_pulse_pin_oe_n_out(left_start_pulse_pin_oe_n_out), .column_outputs_out(column_outputs_out),
   .column_second_ref_out(column_second_ref_out), .line_busy_out(line_busy_out));

// ===== dv/tb_lcd_column_data_loader.sv
// testbench: full lines in both directions, unarmed start, strobe abort
// assumes the controller model in lcdl_ctrl_model
`timescale 1ns/1ps
module tb_lcd_column_data_loader;
   import lcdl_pkg::*;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, dir = 1'b1, ten = 1'b0;
   logic shift, strobe, start, r_out, r_oe_n, l_out, l_oe_n, busy;
   logic [17:0] data;
   logic [NUM_COLUMNS*GRAY_W-1:0] cols;
   logic [NUM_COLUMNS-1:0] sref;
   int mismatches = 0, cmp_count = 0;
   wire logic r_in = r_oe_n ? start : r_out;
   wire logic l_in = l_oe_n ? start : l_out;
   always #2 clk_in = ~clk_in;
   lcdl_ctrl_model ctrl (.clk_in(clk_in), .shift_out(shift), .strobe_out(strobe), .start_out(start),
      .data_out(data));
   lcdl_column_data_loader dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pixel_shift_clock_in(shift),
      .line_latch_strobe_in(strobe), .shift_direction_select_in(dir), .first_reference_open_in(ten),
      .dot0_gray_value_in(data[5:0]), .dot1_gray_value_in(data[11:6]), .dot2_gray_value_in(data[17:12]),
      .right_start_pulse_pin_in(r_in), .right_start_pulse_pin_out(r_out), .right_start_pulse_pin_oe_n_out(r_oe_n),
      .left_start_pulse_pin_in(l_in), .left_start_pulse_pin_out(l_out), .left_start_pulse_pin_oe_n_out(l_oe_n),
      .column_outputs_out(cols), .column_second_ref_out(sref), .line_busy_out(busy));
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic t_unarmed();
      ctrl.line(5, 6'h00);
      chk(busy === 1'b0, "line began before first strobe");
   endtask
   task automatic t_abort();
      ctrl.strobe();
      ctrl.line(10, 6'h15);
      chk(busy === 1'b1, "line not started");
      ctrl.strobe();
      chk(busy === 1'b0, "strobe did not end line");
   endtask
   task automatic t_line(input logic d, input logic t, input logic [5:0] key);
      int i;
      logic [5:0] e;
      dir = d;
      ten = t;
      ctrl.tick(8);
      ctrl.strobe();
      ctrl.line(103, key);
      ctrl.tick(2);
      chk(busy === 1'b0, "no standby after last column");
      chk({l_out, r_out} === {d, ~d}, "start pulse on wrong pin");
      ctrl.edge_out(18'h0);
      ctrl.tick(4);
      chk(busy === 1'b0, "edge in standby restarted line");
      ctrl.strobe();
      for (int c = 0; c < NUM_COLUMNS; c++) begin
         i = d ? c / 3 : 102 - c / 3;
         e = 6'(3 * i + c % 3) ^ key;
         chk(cols[6*c+:6] === e, "column code");
         chk(sref[c] === (t && e == 6'h00), "second reference select");
      end
   endtask
   initial begin
      #200000;
      mismatches++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk_in);
      #1;
      sys_rst_in = 1'b0;
      t_unarmed();
      t_abort();
      t_line(1'b1, 1'b0, 6'h07);
      t_line(1'b0, 1'b1, 6'h32);
      final_report();
   end
endmodule

// ===== include/lcdl_pkg.sv
// constants shared by the column data loader
// assumes one 250 MHz system clock; all pins arrive asynchronously to it
package lcdl_pkg;
   localparam int unsigned NUM_COLUMNS  = 309;
   localparam int unsigned GRAY_W       = 6;
   localparam int unsigned DOTS         = 3;
   localparam int unsigned PIXEL_W      = GRAY_W * DOTS;
   localparam int unsigned CAPTURES     = NUM_COLUMNS / DOTS;
   localparam int unsigned COUNT_W      = 7;
   localparam logic [COUNT_W-1:0] LAST_CAPTURE = 7'h66;
   localparam logic [COUNT_W-1:0] COUNT_ZERO   = 7'h00;
   localparam logic [GRAY_W-1:0]  GRAY_ZERO    = 6'h00;
   localparam int unsigned CLK_PERIOD_NS = 4;

   // bit positions inside the pin synchroniser vector
   localparam int unsigned SY_SHIFT_CLK = 0;
   localparam int unsigned SY_STROBE    = 1;
   localparam int unsigned SY_RIGHT     = 2;
   localparam int unsigned SY_LEFT      = 3;
   localparam int unsigned SY_DIR       = 4;
   localparam int unsigned SY_TEN_REF   = 5;
   localparam int unsigned SY_DATA      = 6;
   localparam int unsigned SYNC_W       = SY_DATA + PIXEL_W;

   typedef enum logic [1:0] {
      LCDL_UNARMED,
      LCDL_STANDBY,
      LCDL_STARTED,
      LCDL_LOADING
   } lcdl_state_e;
endpackage

// ===== src/lcdl_column_data_loader.sv
// column data loader: pixel triplet capture, column latches and holding latches
// assumes pins are asynchronous to clk_in and change far slower than 250 MHz
//
// Overview of operation
// - start pulse input is sampled on each pixel shift clock rising edge.
// - after the start pulse falls, each later shift edge captures the pixel bus.
// - after all 309 columns, enter standby and ignore edges until a new start.
// - a new start accepts data from the first shift edge after its fall.
// - direction low: right pin of a stage feeds next stage's left pin.
// - direction high: left pin of a stage feeds next stage's right pin.
// - pixel bus is 18 bits: three 6-bit gray values, one per dot.
// - each triplet goes to columns 3k+1, 3k+2, 3k+3 in either direction.
// - each of 309 columns holds its own 6-bit converter code.
// - eleven references: code 00h is first reference, 3fh the eleventh.
// - first reference open: code 00h selects the second reference instead.
// - direction high: right pin is input, fill 1 to 309; low reverses.
// - bit 0 of each gray value is lsb, bit 5 msb.
// - latch strobe rising edge copies column data into holding latches.
// - strobe clears the shift logic; operation starts after the first strobe.
`timescale 1ns/1ps
module lcdl_column_data_loader
   import lcdl_pkg::*;
(
   input  wire logic                               clk_in,
   input  wire logic                               sys_rst_in,
   input  wire logic                               pixel_shift_clock_in,
   input  wire logic                               line_latch_strobe_in,
   input  wire logic                               shift_direction_select_in,
   input  wire logic                               first_reference_open_in,
   input  wire logic [lcdl_pkg::GRAY_W-1:0]        dot0_gray_value_in,
   input  wire logic [lcdl_pkg::GRAY_W-1:0]        dot1_gray_value_in,
   input  wire logic [lcdl_pkg::GRAY_W-1:0]        dot2_gray_value_in,
   input  wire logic                               right_start_pulse_pin_in,
   output logic                                    right_start_pulse_pin_out,
   output logic                                    right_start_pulse_pin_oe_n_out,
   input  wire logic                               left_start_pulse_pin_in,
   output logic                                    left_start_pulse_pin_out,
   output logic                                    left_start_pulse_pin_oe_n_out,
   output logic [lcdl_pkg::NUM_COLUMNS*lcdl_pkg::GRAY_W-1:0] column_outputs_out,
   output logic [lcdl_pkg::NUM_COLUMNS-1:0]        column_second_ref_out,
   output logic                                    line_busy_out
);
   import lcdl_pkg::*;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [SYNC_W-1:0] pin_vec;
   logic [SYNC_W-1:0] sync_s1;
   logic [SYNC_W-1:0] sync_s2;
   logic [SYNC_W-1:0] sync_s3;
   logic [SYNC_W-1:0] pin_lvl;
   logic [SYNC_W-1:0] pin_agree;
   logic [SYNC_W-1:0] next_sync_s1;
   logic [SYNC_W-1:0] next_sync_s2;
   logic [SYNC_W-1:0] next_sync_s3;
   logic [SYNC_W-1:0] next_pin_lvl;

   assign pin_vec = {dot2_gray_value_in, dot1_gray_value_in, dot0_gray_value_in,
                     first_reference_open_in, shift_direction_select_in,
                     left_start_pulse_pin_in, right_start_pulse_pin_in,
                     line_latch_strobe_in, pixel_shift_clock_in};

   // a pin counts as changed only once the second and third stages agree
   assign pin_agree = ~(sync_s2 ^ sync_s3);

   always_comb begin
      next_sync_s1 = pin_vec;
      next_sync_s2 = sync_s1;
      next_sync_s3 = sync_s2;
      // agreed copy: each bit follows the third stage only while the stages agree
      next_pin_lvl = (sync_s3 & pin_agree) | (pin_lvl & ~pin_agree);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         sync_s1 <= '0;
         sync_s2 <= '0;
         sync_s3 <= '0;
         pin_lvl <= '0;
      end else begin
         sync_s1 <= next_sync_s1;
         sync_s2 <= next_sync_s2;
         sync_s3 <= next_sync_s3;
         pin_lvl <= next_pin_lvl;
      end
   end

   // ---------------------------------------------------------------
   // agreed levels and edges
   // ---------------------------------------------------------------
   logic                 shift_edge;
   logic                 strobe_edge;
   logic                 dir_high;
   logic                 start_level;
   logic [PIXEL_W-1:0]   pixel_word;

   // an edge is the cycle in which the agreed stages first read high while the copy is still low
   assign shift_edge  = pin_agree[SY_SHIFT_CLK] & sync_s3[SY_SHIFT_CLK] & ~pin_lvl[SY_SHIFT_CLK];
   assign strobe_edge = pin_agree[SY_STROBE] & sync_s3[SY_STROBE] & ~pin_lvl[SY_STROBE];
   assign dir_high    = pin_lvl[SY_DIR];
   // data and start come from the agreed copy, which still holds the value from
   // before the shift edge; they must be steady one clk cycle ahead of it
   assign pixel_word  = pin_lvl[SY_DATA +: PIXEL_W];
   assign start_level = dir_high ? pin_lvl[SY_RIGHT] : pin_lvl[SY_LEFT];

   // ---------------------------------------------------------------
   // line fill control
   // ---------------------------------------------------------------
   lcdl_state_e        state;
   lcdl_state_e        next_state;
   logic [COUNT_W-1:0] capture_count;
   logic [COUNT_W-1:0] next_capture_count;
   logic               start_out;
   logic               next_start_out;
   logic               capture;

   always_comb begin
      next_state         = state;
      next_capture_count = capture_count;
      next_start_out     = start_out;
      capture            = 1'b0;
      if (shift_edge) begin
         next_start_out = 1'b0;  // output start lasts one shift period
      end
      unique case (state)
         LCDL_UNARMED: begin
            next_state = LCDL_UNARMED;
         end
         LCDL_STANDBY: begin
            if (shift_edge && start_level) begin
               next_state = LCDL_STARTED;
            end
         end
         LCDL_STARTED: begin
            if (shift_edge && !start_level) begin
               capture            = 1'b1;
               next_capture_count = COUNT_ZERO + 7'h01;
               next_state         = LCDL_LOADING;
            end
         end
         LCDL_LOADING: begin
            if (shift_edge) begin
               capture = 1'b1;
               if (capture_count == LAST_CAPTURE) begin
                  next_state         = LCDL_STANDBY;
                  next_capture_count = COUNT_ZERO;
                  next_start_out     = 1'b1;
               end else begin
                  next_capture_count = capture_count + 7'h01;
               end
            end
         end
      endcase
      if (strobe_edge) begin
         next_state         = LCDL_STANDBY;
         next_capture_count = COUNT_ZERO;
         next_start_out     = 1'b0;
         capture            = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state         <= LCDL_UNARMED;
         capture_count <= COUNT_ZERO;
         start_out     <= 1'b0;
      end else begin
         state         <= next_state;
         capture_count <= next_capture_count;
         start_out     <= next_start_out;
      end
   end

   // output-side pin is the one opposite the selected input
   assign right_start_pulse_pin_out      = start_out & ~dir_high;
   assign right_start_pulse_pin_oe_n_out = dir_high;
   assign left_start_pulse_pin_out       = start_out & dir_high;
   assign left_start_pulse_pin_oe_n_out  = ~dir_high;
   assign line_busy_out = (state == LCDL_STARTED) || (state == LCDL_LOADING);

   // ---------------------------------------------------------------
   // column data register
   // ---------------------------------------------------------------
   logic [COUNT_W-1:0] group_index;
   logic [GRAY_W-1:0]  col_data      [NUM_COLUMNS];
   logic [GRAY_W-1:0]  next_col_data [NUM_COLUMNS];

   // low direction fills from the far end; dot order within a triplet is fixed
   always_comb begin
      if (state == LCDL_LOADING) begin
         group_index = dir_high ? capture_count : LAST_CAPTURE - capture_count;
      end else begin
         group_index = dir_high ? COUNT_ZERO : LAST_CAPTURE;
      end
   end

   logic [CAPTURES-1:0] group_hit;

   // one decoder per triplet group, shared by its three columns
   genvar gg;
   generate
      for (gg = 0; gg < CAPTURES; gg++) begin : g_grp
         localparam logic [COUNT_W-1:0] GRP_ID = COUNT_W'(gg);
         assign group_hit[gg] = capture && (group_index == GRP_ID);
      end
   endgenerate

   genvar gc;
   generate
      for (gc = 0; gc < NUM_COLUMNS; gc++) begin : g_col
         localparam int unsigned GROUP = gc / DOTS;
         localparam int unsigned DOT   = gc % DOTS;
         logic [GRAY_W-1:0] hold;
         logic [GRAY_W-1:0] next_hold;
         logic              second_ref;
         logic              next_second_ref;

         always_comb begin
            next_col_data[gc] = col_data[gc];
            if (group_hit[GROUP]) begin
               next_col_data[gc] = pixel_word[DOT*GRAY_W +: GRAY_W];
            end
         end

         always_comb begin
            next_hold       = hold;
            next_second_ref = second_ref;
            if (strobe_edge) begin
               next_hold       = col_data[gc];
               // code zero lands on the first reference unless it is open
               next_second_ref = (col_data[gc] == GRAY_ZERO) & pin_lvl[SY_TEN_REF];
            end
         end

         always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
               col_data[gc] <= GRAY_ZERO;
               hold         <= GRAY_ZERO;
               second_ref   <= 1'b0;
            end else begin
               col_data[gc] <= next_col_data[gc];
               hold         <= next_hold;
               second_ref   <= next_second_ref;
            end
         end

         assign column_outputs_out[gc*GRAY_W +: GRAY_W] = hold;
         assign column_second_ref_out[gc]               = second_ref;
      end
   endgenerate
endmodule
